/* hdl/stth_core.sv */
// Controller-facing handshake core of the serial line terminal.
`timescale 1ns/1ps
module stth_core
  import stth_pkg::*;
#(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 128
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  // Process image from the controller
  input  wire logic [7:0]             i_ctrl_byte,
  input  wire logic [DATA_BYTES-1:0][7:0] i_out_data,
  // Process image to the controller
  output logic [7:0]                  o_status_byte,
  output logic [DATA_BYTES-1:0][7:0]  o_in_data,
  // Received characters from the line receiver
  input  wire logic                   i_rx_valid,
  input  wire logic [7:0]             i_rx_data,
  input  wire logic                   i_rx_parity_err,
  input  wire logic                   i_rx_frame_err,
  input  wire logic                   i_rx_overrun_err,
  // Characters to the line transmitter
  output logic                        o_tx_valid,
  output logic [7:0]                  o_tx_data,
  input  wire logic                   i_tx_take,
  // Active line settings
  output logic                        o_link_enable,
  output logic [15:0]                 o_baud_word,
  output logic [15:0]                 o_frame_word,
  output logic [15:0]                 o_feature_word,
  output logic [15:0]                 o_mapped_byte_count
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    stth_state_t                 state;
    logic [7:0]                  ctrl_prev;
    logic [15:0]                 thresh;
    logic [15:0]                 baud;
    logic [15:0]                 frame;
    logic [15:0]                 feature;
    logic [15:0]                 mapped;
    logic [15:0]                 act_thresh;
    logic [15:0]                 act_baud;
    logic [15:0]                 act_frame;
    logic [15:0]                 act_feature;
    logic [15:0]                 act_mapped;
    logic [15:0]                 diag;
    logic                        send_accept;
    logic                        receive_offer;
    logic                        reinit_ack;
    logic                        full_flag;
    logic                        first_done;
    logic [LEN_W-1:0]            rx_len;
    logic [DATA_BYTES-1:0][7:0]  rx_buf;
    logic [LEN_W-1:0]            cnt;
    logic [LEN_W-1:0]            goal;
    logic [7:0]                  status;
    logic [DATA_BYTES-1:0][7:0]  in_data;
    logic                        tx_valid;
    logic [7:0]                  tx_data;
    logic                        link_en;
  } stth_core_st_t;

  localparam stth_core_st_t RESET_ST = '{
    state: S_IDLE, ctrl_prev: '0, thresh: RST_THRESH, baud: RST_BAUD,
    frame: RST_FRAME, feature: RST_FEATURE, mapped: RST_MAPPED,
    act_thresh: RST_THRESH, act_baud: RST_BAUD, act_frame: RST_FRAME,
    act_feature: RST_FEATURE, act_mapped: RST_MAPPED, diag: '0,
    send_accept: 1'b0, receive_offer: 1'b0, reinit_ack: 1'b0,
    full_flag: 1'b0, first_done: 1'b0, rx_len: '0, rx_buf: '0, cnt: '0,
    goal: '0, status: '0, in_data: '0, tx_valid: 1'b0, tx_data: '0,
    link_en: 1'b1};

  stth_core_st_t s;
  stth_core_st_t n;

  stth_fifo_if tx_if();
  stth_fifo_if rx_if();

  logic             tx_push;
  logic             tx_pop;
  logic             rx_push;
  logic             rx_pop;
  logic             flush;
  logic [7:0]       tx_wdata;
  logic [15:0]      rd_val;
  logic [15:0]      wr_val;
  logic [15:0]      diag_set;
  logic [15:0]      diag_clr;
  logic [IDX_W-1:0] idx;
  logic             reg_mode;
  logic             pd_mode;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte count from a register low byte, held to the legal 1..5 range.
  function automatic logic [LEN_W-1:0] map_count(input logic [7:0] v);
    if (v < 8'(MAP_MIN)) begin
      return MAP_MIN;
    end else if (v > 8'(MAP_MAX)) begin
      return MAP_MAX;
    end
    return v[LEN_W-1:0];
  endfunction

  // Smaller of a byte count and a FIFO level.
  function automatic logic [LEN_W-1:0] min_count(input logic [LEN_W-1:0] c,
                                                 input logic [LVL_W-1:0] lvl);
    if (lvl < LVL_W'(c)) begin
      return lvl[LEN_W-1:0];
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n        = s;
    tx_push  = 1'b0;
    tx_pop   = 1'b0;
    rx_push  = 1'b0;
    rx_pop   = 1'b0;
    flush    = 1'b0;
    tx_wdata = '0;
    diag_set = '0;
    diag_clr = '0;
    reg_mode = i_ctrl_byte[CB_REG];
    pd_mode  = !reg_mode;
    idx      = i_ctrl_byte[IDX_W-1:0];
    wr_val   = {i_out_data[0], i_out_data[1]};
    n.ctrl_prev = i_ctrl_byte;

    case (idx)
      A_TX_LVL:  rd_val = 16'(tx_if.level);
      A_RX_LVL:  rd_val = 16'(rx_if.level);
      A_DIAG:    rd_val = s.diag;
      A_THRESH:  rd_val = s.thresh;
      A_BAUD:    rd_val = s.baud;
      A_FRAME:   rd_val = s.frame;
      A_FEATURE: rd_val = s.feature;
      A_MAPPED:  rd_val = s.mapped;
      default:   rd_val = '0;
    endcase

    // A write is taken once, when a new write command byte appears.
    if (reg_mode && i_ctrl_byte[CB_WR] && (i_ctrl_byte != s.ctrl_prev)) begin
      case (idx)
        A_DIAG:    diag_clr  = wr_val;
        A_THRESH:  n.thresh  = wr_val;
        A_BAUD:    n.baud    = wr_val;
        A_FRAME:   n.frame   = wr_val;
        A_FEATURE: n.feature = wr_val;
        A_MAPPED:  n.mapped  = wr_val;
        default:   n.mapped  = n.mapped;
      endcase
    end

    // Receive path: errored or unwanted characters never reach the FIFO.
    rx_push = i_rx_valid && s.link_en && !s.full_flag && !rx_if.full
              && !i_rx_parity_err && !i_rx_frame_err
              && !i_rx_overrun_err;
    if (i_rx_valid) begin
      diag_set[DG_PARITY]  = i_rx_parity_err;
      diag_set[DG_FRAME]   = i_rx_frame_err;
      diag_set[DG_OVERRUN] = i_rx_overrun_err;
      diag_set[DG_LOST]    = s.link_en && (s.full_flag || rx_if.full);
    end

    // Transmit output stage keeps the line port registered.
    if (!s.link_en) begin
      n.tx_valid = 1'b0;
    end else if ((!s.tx_valid || i_tx_take) && !tx_if.empty) begin
      tx_pop     = 1'b1;
      n.tx_valid = 1'b1;
      n.tx_data  = tx_if.rdata;
    end else if (i_tx_take) begin
      n.tx_valid = 1'b0;
    end

    case (s.state)
      S_IDLE: begin
        n.cnt = '0;
        if (pd_mode && i_ctrl_byte[PD_REINIT]) begin
          n.state = S_INIT;
        end else if (pd_mode && (i_ctrl_byte[PD_SEND] != s.send_accept)) begin
          n.goal  = min_count(i_ctrl_byte[CB_LEN_LSB +: LEN_W],
                              LVL_W'(MAP_MAX));
          n.state = S_TXLOAD;
        end else if (pd_mode && (i_ctrl_byte[PD_RXACK] == s.receive_offer)
                     && !rx_if.empty) begin
          n.goal   = s.first_done ?
                     min_count(map_count(s.act_mapped[7:0]), rx_if.level) :
                     FIRST_LEN;
          n.rx_buf = '0;
          n.state  = S_RXPOP;
        end
      end
      S_TXLOAD: begin
        if (pd_mode && i_ctrl_byte[PD_REINIT]) begin
          n.state = S_INIT;
        end else if (s.cnt == s.goal) begin
          n.send_accept = !s.send_accept;
          n.state       = S_IDLE;
        end else if (!tx_if.full) begin
          tx_push  = 1'b1;
          tx_wdata = i_out_data[s.cnt];
          n.cnt    = s.cnt + 1'b1;
        end
      end
      S_RXPOP: begin
        if (s.cnt == s.goal) begin
          n.rx_len        = s.cnt;
          n.receive_offer = !s.receive_offer;
          n.first_done    = 1'b1;
          n.state         = S_IDLE;
        end else begin
          rx_pop          = 1'b1;
          n.rx_buf[s.cnt] = rx_if.rdata;
          n.cnt           = s.cnt + 1'b1;
        end
      end
      S_INIT: begin
        flush         = 1'b1;
        rx_push       = 1'b0;
        tx_push       = 1'b0;
        tx_pop        = 1'b0;
        n.tx_valid    = 1'b0;
        n.link_en     = 1'b0;
        n.full_flag   = 1'b0;
        n.first_done  = 1'b0;
        n.act_thresh  = s.thresh;
        n.act_baud    = s.baud;
        n.act_frame   = s.frame;
        n.act_feature = s.feature;
        n.act_mapped  = s.mapped;
        n.reinit_ack  = 1'b1;
        if (!(pd_mode && i_ctrl_byte[PD_REINIT])) begin
          n.reinit_ack = 1'b0;
          n.link_en    = 1'b1;
          n.state      = S_IDLE;
        end
      end
      default: begin
        n.state = S_IDLE;
      end
    endcase

    if (s.state != S_INIT) begin
      n.full_flag = (rx_if.level >= s.act_thresh[7:0]) || rx_if.full;
    end
    // A new error wins over a clear in the same cycle.
    n.diag = (s.diag & ~diag_clr) | diag_set;

    // Process image toward the controller.
    if (reg_mode && i_ctrl_byte[CB_WR]) begin
      n.status  = {1'b1, 1'b0, idx};
      n.in_data = '0;
    end else if (reg_mode) begin
      n.status     = i_ctrl_byte;
      n.in_data    = '0;
      n.in_data[0] = rd_val[15:8];
      n.in_data[1] = rd_val[7:0];
    end else begin
      n.status  = {1'b0, n.rx_len, n.full_flag, n.reinit_ack,
                   n.receive_offer, n.send_accept};
      n.in_data = n.rx_buf;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      s <= RESET_ST;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  assign tx_if.push  = tx_push;
  assign tx_if.pop   = tx_pop;
  assign tx_if.flush = flush;
  assign tx_if.wdata = tx_wdata;
  assign rx_if.push  = rx_push;
  assign rx_if.pop   = rx_pop;
  assign rx_if.flush = flush;
  assign rx_if.wdata = i_rx_data;

  stth_fifo #(.DEPTH(TX_DEPTH)) u_tx_fifo (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .f       (tx_if.mem)
  );

  stth_fifo #(.DEPTH(RX_DEPTH)) u_rx_fifo (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .f       (rx_if.mem)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_status_byte       = s.status;
  assign o_in_data           = s.in_data;
  assign o_tx_valid          = s.tx_valid;
  assign o_tx_data           = s.tx_data;
  assign o_link_enable       = s.link_en;
  assign o_baud_word         = s.act_baud;
  assign o_frame_word        = s.act_frame;
  assign o_feature_word      = s.act_feature;
  assign o_mapped_byte_count = s.act_mapped;
endmodule

/* hdl/stth_pkg.sv */
// Shared constants and types of the serial terminal handshake block.
package stth_pkg;
  localparam int          DATA_BYTES  = 5;
  localparam int          LVL_W       = 8;
  localparam int          IDX_W       = 6;
  // Control and status byte bit positions.
  localparam int          CB_REG      = 7;
  localparam int          CB_WR       = 6;
  localparam int          CB_LEN_LSB  = 4;
  localparam int          LEN_W       = 3;
  localparam int          PD_REINIT   = 2;
  localparam int          PD_RXACK    = 1;
  localparam int          PD_SEND     = 0;
  // Configuration register indices.
  localparam logic [5:0]  A_TX_LVL    = 6'h00;
  localparam logic [5:0]  A_RX_LVL    = 6'h01;
  localparam logic [5:0]  A_DIAG      = 6'h06;
  localparam logic [5:0]  A_THRESH    = 6'h12;
  localparam logic [5:0]  A_BAUD      = 6'h20;
  localparam logic [5:0]  A_FRAME     = 6'h21;
  localparam logic [5:0]  A_FEATURE   = 6'h22;
  localparam logic [5:0]  A_MAPPED    = 6'h23;
  // Reset values.
  localparam logic [15:0] RST_THRESH  = 16'h0080;
  localparam logic [15:0] RST_BAUD    = 16'h0006;
  localparam logic [15:0] RST_FRAME   = 16'h0003;
  localparam logic [15:0] RST_FEATURE = 16'h0002;
  localparam logic [15:0] RST_MAPPED  = 16'h0003;
  // Byte counts.
  localparam logic [2:0]  MAP_MIN     = 3'h1;
  localparam logic [2:0]  MAP_MAX     = 3'h5;
  localparam logic [2:0]  FIRST_LEN   = 3'h1;
  // Diagnostic word bits.
  localparam int          DG_PARITY   = 0;
  localparam int          DG_FRAME    = 1;
  localparam int          DG_OVERRUN  = 2;
  localparam int          DG_LOST     = 3;

  typedef enum logic [3:0] {
    S_IDLE   = 4'h1,
    S_TXLOAD = 4'h2,
    S_RXPOP  = 4'h4,
    S_INIT   = 4'h8
  } stth_state_t;
endpackage

/* hdl/stth_fifo_if.sv */
// Byte FIFO connection between the handshake core and its FIFOs.
`timescale 1ns/1ps
interface stth_fifo_if;
  import stth_pkg::*;
  logic             push;
  logic             pop;
  logic             flush;
  logic [7:0]       wdata;
  logic [7:0]       rdata;
  logic [LVL_W-1:0] level;
  logic             full;
  logic             empty;
  modport ctl (output push, pop, flush, wdata, input rdata, level, full, empty);
  modport mem (input push, pop, flush, wdata, output rdata, level, full, empty);
endinterface

/* hdl/stth_fifo.sv */
// Show-ahead byte FIFO with flush, used for both send and receive paths.
`timescale 1ns/1ps
module stth_fifo
  import stth_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // FIFO port
  stth_fifo_if.mem  f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0]         wp;
    logic [AW-1:0]         rp;
    logic [LVL_W-1:0]      cnt;
  } stth_fifo_st_t;

  stth_fifo_st_t s;
  stth_fifo_st_t n;
  logic          do_push;
  logic          do_pop;

  always_comb begin
    n       = s;
    do_push = f.push && (s.cnt != FULL_LVL);
    do_pop  = f.pop && (s.cnt != '0);
    if (f.flush) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end else begin
      if (do_push) begin
        n.mem[s.wp] = f.wdata;
        n.wp        = s.wp + 1'b1;
      end
      if (do_pop) begin
        n.rp = s.rp + 1'b1;
      end
      if (do_push && !do_pop) begin
        n.cnt = s.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
        n.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign f.rdata = s.mem[s.rp];
  assign f.level = s.cnt;
  assign f.full  = (s.cnt == FULL_LVL);
  assign f.empty = (s.cnt == '0);
endmodule

/* testbench/stth_core_sva.sv */
// Assertion checker bound to the serial terminal handshake core.
`timescale 1ns/1ps
module stth_core_chk
  import stth_pkg::*;
#(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 128
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  // Process image
  input  wire logic [7:0]                 i_ctrl_byte,
  input  wire logic [7:0]                 o_status_byte,
  input  wire logic [DATA_BYTES-1:0][7:0] o_in_data,
  // Transmit side and link
  input  wire logic                       o_tx_valid,
  input  wire logic [7:0]                 o_tx_data,
  input  wire logic                       i_tx_take,
  input  wire logic                       o_link_enable
);
  // ----
  // Register mode
  // ----
  property p_rd_echo;
    @(posedge i_clk) disable iff (!i_rst_b) i_ctrl_byte[CB_REG] && !i_ctrl_byte[CB_WR]
      |=> o_status_byte == $past(i_ctrl_byte) && o_in_data[4:2] == '0;
  endproperty
  a_rd_echo: assert property (p_rd_echo) else $error("read echo wrong");
  property p_wr_ack;
    @(posedge i_clk) disable iff (!i_rst_b) i_ctrl_byte[CB_REG] && i_ctrl_byte[CB_WR]
      |=> o_status_byte == {2'b10, $past(i_ctrl_byte[5:0])} && o_in_data == '0;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write ack wrong");
  // ----
  // Process data mode
  // ----
  property p_data_top;
    @(posedge i_clk) disable iff (!i_rst_b) !i_ctrl_byte[CB_REG] |=> !o_status_byte[7];
  endproperty
  a_data_top: assert property (p_data_top) else $error("status top bit set");
  property p_ia_rise;
    @(posedge i_clk) disable iff (!i_rst_b) (!i_ctrl_byte[7] && i_ctrl_byte[PD_REINIT]) [*3]
      |=> o_status_byte[PD_REINIT] && !o_link_enable;
  endproperty
  a_ia_rise: assert property (p_ia_rise) else $error("reinit ack late");
  property p_ia_fall;
    @(posedge i_clk) disable iff (!i_rst_b) !i_ctrl_byte[7] && !i_ctrl_byte[PD_REINIT]
      && !o_status_byte[7] && o_status_byte[PD_REINIT]
      |=> !o_status_byte[PD_REINIT] && o_link_enable;
  endproperty
  a_ia_fall: assert property (p_ia_fall) else $error("reinit ack stuck");
  property p_tx_hold;
    @(posedge i_clk) disable iff (!i_rst_b) o_tx_valid && !i_tx_take
      |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
  property p_offer;
    @(posedge i_clk) disable iff (!i_rst_b) !o_status_byte[7] && !$past(o_status_byte[7])
      && !o_status_byte[2] && $changed(o_status_byte[PD_RXACK])
      |-> o_status_byte[6:4] inside {[3'h1:3'h5]};
  endproperty
  a_offer: assert property (p_offer) else $error("offer length wrong");
  property p_ack_wait;
    @(posedge i_clk) disable iff (!i_rst_b) !o_status_byte[7] && !$past(o_status_byte[7])
      && !o_status_byte[2] && $changed(o_status_byte[PD_RXACK])
      |-> $past(i_ctrl_byte[PD_RXACK]) == $past(o_status_byte[PD_RXACK]);
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("offer before ack");
endmodule

bind stth_core stth_core_chk #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH)) u_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ctrl_byte(i_ctrl_byte),
  .o_status_byte(o_status_byte), .o_in_data(o_in_data), .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data), .i_tx_take(i_tx_take), .o_link_enable(o_link_enable));

/* testbench/stth_line_model.sv */
// Serial line model: a transmitter that stalls and a receiver source.
`timescale 1ns/1ps
module stth_line_model (
  // Clock
  input  wire logic i_clk,
  // Transmit side
  output logic      o_tx_take,
  // Receive side
  output logic       o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic [2:0] o_rx_err
);
  initial begin
    o_tx_take = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data = 8'hA5;
    o_rx_err = 3'h0;
  end
  // A busy line stalls at random, so the core must hold its offered byte.
  always @(negedge i_clk) o_tx_take <= ($urandom % 3) != 0;
  task automatic put(input logic [7:0] d, input logic [2:0] e);
    @(negedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_data <= d;
    o_rx_err <= e;
    @(negedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~d;
    o_rx_err <= 3'h0;
  endtask
endmodule

/* testbench/stth_core_bench.sv */
// Self-checking bench of the serial terminal handshake core.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module stth_core_bench;
  import stth_pkg::*;
  logic                       i_clk;
  logic                       i_rst_b;
  logic [7:0]                 ctrl;
  logic [DATA_BYTES-1:0][7:0] dout;
  logic [7:0]                 st;
  logic [DATA_BYTES-1:0][7:0] din;
  logic                       tx_valid;
  logic                       take;
  logic                       rx_valid;
  logic                       link;
  logic [7:0]                 tx_data;
  logic [7:0]                 rx_data;
  logic [7:0]                 exp_b;
  logic [2:0]                 rx_err;
  logic [15:0]                mapped;
  logic [15:0]                baud;
  logic [15:0]                frame;
  logic [15:0]                feature;
  logic                       rq;
  logic                       ak;
  logic [7:0]                 exp_tx[$];
  int                         n_mismatch = 0;
  int                         checks = 0;

  stth_core #(.TX_DEPTH(16), .RX_DEPTH(128)) DUT (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ctrl_byte(ctrl), .i_out_data(dout),
    .o_status_byte(st), .o_in_data(din), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_parity_err(rx_err[0]), .i_rx_frame_err(rx_err[1]), .i_rx_overrun_err(rx_err[2]),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_take(take), .o_link_enable(link),
    .o_baud_word(baud), .o_frame_word(frame), .o_feature_word(feature),
    .o_mapped_byte_count(mapped));
  stth_line_model u_line (
    .i_clk(i_clk), .o_tx_take(take), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_err(rx_err));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wait_st(input int b, input logic v);
    int k;
    for (k = 0; k < 400 && st[b] !== v; k++) @(negedge i_clk);
    if (st[b] !== v) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic reg_op(input logic [7:0] c, input logic [15:0] v, input logic [7:0] es,
                        input logic [15:0] ev);
    @(negedge i_clk);
    ctrl = c;
    dout[0] = v[15:8];
    dout[1] = v[7:0];
    @(negedge i_clk);
    `CHK(st, es)
    `CHK({din[0], din[1]}, ev)
  endtask

  // Transmitted bytes are compared in order against the notes of the driver.
  always @(posedge i_clk) begin
    if (i_rst_b && tx_valid === 1'b1 && take === 1'b1) begin
      if (exp_tx.size() == 0) begin
        `CHK(tx_valid, 1'b0)
      end else begin
        exp_b = exp_tx.pop_front();
        `CHK(tx_data, exp_b)
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    void'($urandom(32'hA68FEFF7));
    i_rst_b = 1'b0;
    ctrl = 8'h00;
    dout = '0;
    rq = 1'b0;
    ak = 1'b0;
    repeat (4) @(negedge i_clk);
    i_rst_b = 1'b1;
    `CHK(mapped, 16'h0003)
    `CHK({baud, frame, feature}, 48'h0006_0003_0002)
    reg_op(8'hA3, 16'h0000, 8'hA3, 16'h0003);
    reg_op(8'hDF, 16'h1235, 8'h9F, 16'h0000);
    reg_op(8'hE3, 16'h0005, 8'hA3, 16'h0000);
    reg_op(8'hD2, 16'h0004, 8'h92, 16'h0000);
    reg_op(8'hE0, 16'h0007, 8'hA0, 16'h0000);
    reg_op(8'hA3, 16'h0000, 8'hA3, 16'h0005);
    reg_op(8'h9F, 16'h0000, 8'h9F, 16'h0000);
    `CHK(mapped, 16'h0003)
    `CHK(baud, 16'h0006)
    ctrl = 8'h04;
    @(negedge i_clk);
    wait_st(PD_REINIT, 1'b1);
    `CHK(link, 1'b0)
    `CHK(mapped, 16'h0005)
    `CHK(baud, 16'h0007)
    // Hold the request a little longer so the acknowledge is seen standing.
    repeat (2) @(negedge i_clk);
    ctrl = 8'h00;
    wait_st(PD_REINIT, 1'b0);
    `CHK(link, 1'b1)
    // Every length code, including the two above five that must be capped.
    for (int n = 0; n < 8; n++) begin
      for (int i = 0; i < DATA_BYTES; i++) dout[i] = 8'($urandom);
      for (int i = 0; i < DATA_BYTES && i < n; i++) exp_tx.push_back(dout[i]);
      rq = ~rq;
      ctrl = {1'b0, 3'(n), 2'b00, ak, rq};
      @(negedge i_clk);
      wait_st(PD_SEND, rq);
    end
    for (int k = 0; k < 500 && exp_tx.size() > 0; k++) @(negedge i_clk);
    `CHK(exp_tx.size(), 0)
    u_line.put(8'h41, 3'h0);
    u_line.put(8'h42, 3'h1);
    u_line.put(8'h43, 3'h0);
    u_line.put(8'h44, 3'h0);
    wait_st(PD_RXACK, 1'b1);
    `CHK(st[6:4], 3'h1)
    `CHK(din[0], 8'h41)
    ak = 1'b1;
    ctrl = {5'h00, 1'b0, ak, rq};
    @(negedge i_clk);
    wait_st(PD_RXACK, 1'b0);
    `CHK(st[6:4], 3'h2)
    `CHK(din, {24'h0, 8'h44, 8'h43})
    reg_op(8'h86, 16'h0000, 8'h86, 16'h0001);
    // Offer and ack now differ, so arrivals pile up in the receive FIFO.
    ctrl = {5'h00, 1'b0, ak, rq};
    for (int i = 0; i < 5; i++) u_line.put(8'h50 + 8'(i), 3'h0);
    @(negedge i_clk);
    `CHK(st[3], 1'b1)
    reg_op(8'h86, 16'h0000, 8'h86, 16'h0009);
    reg_op(8'h81, 16'h0000, 8'h81, 16'h0004);
    reg_op(8'hC6, 16'h0009, 8'h86, 16'h0000);
    reg_op(8'h86, 16'h0000, 8'h86, 16'h0000);
    complete_run();
  end
endmodule
